// ### design/cbss_consts.svh
// Register offsets, reset values, codes and timing counts of the coefficient bank sequencer.
`ifndef CBSS_CONSTS_SVH
`define CBSS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CBSS_IDX_SYSCTL2 8'h05
`define CBSS_IDX_RAMP 8'h1A
`define CBSS_IDX_TRIM 8'h1B
`define CBSS_IDX_BANKMODE 8'h50
`define CBSS_IDX_STATUS 8'h60

// ----------------------------------------------------------------------------
// Bankable coefficient locations
// ----------------------------------------------------------------------------
`define CBSS_BK_A_LO 8'h29
`define CBSS_BK_A_HI 8'h36
`define CBSS_BK_B_LO 8'h3A
`define CBSS_BK_B_HI 8'h3F
`define CBSS_BK_C 8'h59
`define CBSS_BK_D 8'h5D
`define CBSS_SLOT_B 5'h0E
`define CBSS_SLOT_C 5'h14
`define CBSS_SLOT_D 5'h15
`define CBSS_SLOTS 22
`define CBSS_BANKS 3
`define CBSS_COEF_W 26

// ----------------------------------------------------------------------------
// Fields, codes and reset values
// ----------------------------------------------------------------------------
`define CBSS_SHUTDOWN_BIT 6
`define CBSS_SYSCTL2_RST 8'h40
`define CBSS_RAMP_RST 5'h00
`define CBSS_TRIM_RST 8'h00
`define CBSS_MODE_DIS 3'h0
`define CBSS_MODE_UPD1 3'h1
`define CBSS_MODE_UPD3 3'h3
`define CBSS_MODE_AUTO 3'h4
`define CBSS_RATE_32K 2'h0
`define CBSS_RATE_OTHER 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CBSS_CLK_HZ 20000000
`define CBSS_SETTLE_MS 240
`define CBSS_SETTLE_CYC (`CBSS_SETTLE_MS * (`CBSS_CLK_HZ / 1000))
`define CBSS_RAMP_STEP_NS 2062500
`define CBSS_RAMP_STEP_CYC ((`CBSS_RAMP_STEP_NS * (`CBSS_CLK_HZ / 1000000)) / 1000)

`endif

// ### design/cbss_pkg.sv
// Types shared by the coefficient bank sequencer.
`default_nettype none
package cbss_pkg;

	typedef logic signed [25:0] cbss_coef_t;

	typedef enum logic [2:0] {
		CBSS_BUS_IDLE = 3'b001,
		CBSS_BUS_PREP = 3'b010,
		CBSS_BUS_ANS = 3'b100
	} cbss_bus_state_t;

	typedef enum logic [1:0] {
		CBSS_CP_IDLE = 2'b01,
		CBSS_CP_RUN = 2'b10
	} cbss_copy_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] idx;
		logic [31:0] wdata;
	} cbss_req_t;

	typedef struct packed {
		logic hit;
		logic [4:0] slot;
	} cbss_slot_t;

endpackage : cbss_pkg
`default_nettype wire

// ### design/cbss_coef_mem.sv
// Stored coefficient banks: simple dual-port memory with registered read data.
`default_nettype none
module cbss_coef_mem #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 66,
	parameter int ADDR_W = $clog2(DEPTH)
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	if (DEPTH < 2 || WIDTH < 1 || (1 << ADDR_W) < DEPTH) begin : g_bad_cfg
		$error("cbss_coef_mem: unusable width or depth");
	end

	// The array has no reset so that it maps onto block RAM.
	always_ff @(posedge i_clock) begin
		if (i_wr_en) begin
			mem_reg[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= mem_reg[i_rd_addr];
		end
	end

endmodule : cbss_coef_mem
`default_nettype wire

// ### design/cbss_top.sv
// Coefficient bank switching and shutdown sequencing behind an Avalon-MM slave.
`include "cbss_consts.svh"
`default_nettype none
// Operation
// R1: three banks, default mapping by sample rate
// R2: only bankable locations are banked
// R3: mode 000 resets, writes act immediately
// R4: disabled mode ignores later rate changes
// R5: codes 001-011 route writes into banks
// R6: code 100 loads bank per detected rate
// R7: host loads all banks before auto
// R8: bank writes leave active coefficients untouched
// R9: gains are 26-bit signed 3.23 values
// R10: top bit set means negative
// R11: gains travel as 32-bit words, upper ignored
// R12: host holds reset, then waits 13.5 ms
// R13: host trims oscillator, waits 50 ms
// R14: host limits normal-operation actions
// R15: shutdown changes held until settle time
// R16: host enters shutdown writing 0x40
// R17: shutdown idle needs no stable clocks
// R18: host leaves shutdown writing 0x00
// R19: host waits start ramp after exit
// R20: power-down via shutdown or pin low
// R21: inputs low after reset held 2 us
// R22: five-bit field sets start/stop ramp
module cbss_top #(
	parameter int SETTLE_CYCLES = `CBSS_SETTLE_CYC,
	parameter int RAMP_STEP_CYCLES = `CBSS_RAMP_STEP_CYC
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [1:0] i_rate_code,
	input wire logic [4:0] i_coef_rd_slot,
	output cbss_pkg::cbss_coef_t o_coef_rd_data,
	output logic o_shutdown,
	output logic [4:0] o_ramp_period,
	output logic [1:0] o_active_bank,
	output logic o_settled
);
	localparam int SLOTS = `CBSS_SLOTS;
	localparam int DEPTH = `CBSS_BANKS * `CBSS_SLOTS;
	if (SETTLE_CYCLES < 1 || RAMP_STEP_CYCLES < 1 || RAMP_STEP_CYCLES > 1000000) begin : g_bad
		$error("cbss_top: settle or ramp step count out of range");
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic cbss_pkg::cbss_slot_t slot_of(input logic [7:0] idx);
		cbss_pkg::cbss_slot_t s;
		s = '0;
		if (idx >= `CBSS_BK_A_LO && idx <= `CBSS_BK_A_HI) begin
			s.hit = 1'b1;
			s.slot = 5'(idx - `CBSS_BK_A_LO);
		end else if (idx >= `CBSS_BK_B_LO && idx <= `CBSS_BK_B_HI) begin
			s.hit = 1'b1;
			s.slot = 5'(idx - `CBSS_BK_B_LO) + `CBSS_SLOT_B;
		end else if (idx == `CBSS_BK_C) begin
			s.hit = 1'b1;
			s.slot = `CBSS_SLOT_C;
		end else if (idx == `CBSS_BK_D) begin
			s.hit = 1'b1;
			s.slot = `CBSS_SLOT_D;
		end
		return s;
	endfunction : slot_of
	function automatic logic [1:0] bank_of_rate(input logic [1:0] rate);
		if (rate == `CBSS_RATE_32K) begin
			return 2'h0;
		end else if (rate == `CBSS_RATE_OTHER) begin
			return 2'h2;
		end
		return 2'h1;
	endfunction : bank_of_rate
	function automatic logic [6:0] mem_addr(input logic [1:0] bank, input logic [4:0] slot);
		return 7'({5'h00, bank} * 7'd22) + {2'h0, slot};
	endfunction : mem_addr
	// Bits above the coefficient width read back as zero.
	function automatic logic [31:0] coef_word(input cbss_pkg::cbss_coef_t c);
		return {6'h00, c};
	endfunction : coef_word

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	cbss_pkg::cbss_bus_state_t bus_st_reg;
	cbss_pkg::cbss_copy_state_t cp_st_reg;
	cbss_pkg::cbss_req_t req;
	cbss_pkg::cbss_slot_t req_slot;
	cbss_pkg::cbss_coef_t [SLOTS-1:0] active_reg;
	cbss_pkg::cbss_coef_t mem_rdata;
	logic [2:0] mode_reg;
	logic [7:0] sysctl2_reg, trim_reg;
	logic [4:0] cp_cnt_reg;
	logic [31:0] settle_cnt_reg, settle_total, rb_next;
	logic [1:0] upd_bank;
	logic stale_reg, armed_reg, upd_mode, bus_start, take, take_wr, auto_need, cp_start, mem_we;
	logic [6:0] mem_raddr;

	assign req = '{rd: i_avs_read, wr: i_avs_write, idx: i_avs_address[9:2],
		wdata: i_avs_writedata};
	assign req_slot = slot_of(req.idx);
	assign upd_mode = mode_reg >= `CBSS_MODE_UPD1 && mode_reg <= `CBSS_MODE_UPD3;
	assign upd_bank = mode_reg[1:0] - 2'h1;
	assign take = bus_st_reg == cbss_pkg::CBSS_BUS_ANS && (req.rd || req.wr);
	assign take_wr = take && req.wr;

	// ------------------------------------------------------------------------
	// Bank copy engine
	// ------------------------------------------------------------------------
	// Rate changes in shutdown are ignored; the reload waits for the exit.
	assign auto_need = mode_reg == `CBSS_MODE_AUTO && !o_shutdown && // R4 R6 R17
		(stale_reg || bank_of_rate(i_rate_code) != o_active_bank); // R1
	assign cp_start = cp_st_reg == cbss_pkg::CBSS_CP_IDLE &&
		bus_st_reg == cbss_pkg::CBSS_BUS_IDLE && auto_need;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cp_st_reg <= cbss_pkg::CBSS_CP_IDLE;
			cp_cnt_reg <= 5'h00;
			stale_reg <= 1'b0;
			o_active_bank <= 2'h0;
		end else begin
			if (take_wr && req.idx == `CBSS_IDX_BANKMODE &&
				req.wdata[2:0] == `CBSS_MODE_AUTO) begin
				stale_reg <= 1'b1;
			end else if (cp_start) begin
				stale_reg <= 1'b0;
			end
			unique case (cp_st_reg)
				cbss_pkg::CBSS_CP_IDLE: begin
					if (cp_start) begin
						cp_st_reg <= cbss_pkg::CBSS_CP_RUN;
						cp_cnt_reg <= 5'h00;
						o_active_bank <= bank_of_rate(i_rate_code); // R1 R6
					end
				end
				cbss_pkg::CBSS_CP_RUN: begin
					if (cp_cnt_reg == 5'(SLOTS)) begin
						cp_st_reg <= cbss_pkg::CBSS_CP_IDLE;
					end else begin
						cp_cnt_reg <= cp_cnt_reg + 5'h01;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Stored banks
	// ------------------------------------------------------------------------
	assign mem_we = take_wr && req_slot.hit && upd_mode; // R2 R5
	assign mem_raddr = cp_st_reg == cbss_pkg::CBSS_CP_RUN ?
		mem_addr(o_active_bank, cp_cnt_reg) : mem_addr(upd_bank, req_slot.slot);
	cbss_coef_mem #(
		.WIDTH(`CBSS_COEF_W),
		.DEPTH(DEPTH),
		.ADDR_W(7)
	) u_mem (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_wr_en(mem_we),
		.i_wr_addr(mem_addr(upd_bank, req_slot.slot)),
		.i_wr_data(req.wdata[25:0]), // R11
		.i_rd_addr(mem_raddr),
		.o_rd_data(mem_rdata)
	);

	// ------------------------------------------------------------------------
	// Active coefficients
	// ------------------------------------------------------------------------
	// A bank write never lands here; only the copy engine brings it across.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			active_reg <= '0;
		end else if (cp_st_reg == cbss_pkg::CBSS_CP_RUN && cp_cnt_reg != 5'h00) begin
			active_reg[cp_cnt_reg - 5'h01] <= mem_rdata; // R6 R8
		end else if (take_wr && req_slot.hit && !upd_mode) begin
			active_reg[req_slot.slot] <= req.wdata[25:0]; // R3 R9 R11
		end
	end

	// Signed type carries the sign in bit 25 to the audio path.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_coef_rd_data <= '0;
		end else if (i_coef_rd_slot < 5'(SLOTS)) begin
			o_coef_rd_data <= active_reg[i_coef_rd_slot]; // R10
		end else begin
			o_coef_rd_data <= '0;
		end
	end

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_reg <= `CBSS_MODE_DIS; // R3
			sysctl2_reg <= `CBSS_SYSCTL2_RST;
			trim_reg <= `CBSS_TRIM_RST;
			o_ramp_period <= `CBSS_RAMP_RST;
		end else if (take_wr) begin
			unique case (req.idx)
				`CBSS_IDX_BANKMODE: mode_reg <= req.wdata[2:0]; // R5 R6
				`CBSS_IDX_SYSCTL2: sysctl2_reg <= req.wdata[7:0];
				`CBSS_IDX_TRIM: trim_reg <= req.wdata[7:0];
				`CBSS_IDX_RAMP: o_ramp_period <= req.wdata[4:0]; // R22
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Settle timer after trim
	// ------------------------------------------------------------------------
	// The wait covers the fixed settle time plus 1.3 start ramps.
	assign settle_total = 32'(SETTLE_CYCLES) + // R15
		(32'(o_ramp_period) * 32'(RAMP_STEP_CYCLES) * 32'd13) / 32'd10; // R22
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_cnt_reg <= 32'h0000_0000;
			armed_reg <= 1'b0;
			o_settled <= 1'b0;
		end else if (take_wr && req.idx == `CBSS_IDX_TRIM) begin
			settle_cnt_reg <= settle_total;
			armed_reg <= 1'b1;
			o_settled <= 1'b0;
		end else begin
			if (settle_cnt_reg != 32'h0000_0000) begin
				settle_cnt_reg <= settle_cnt_reg - 32'h0000_0001;
			end
			o_settled <= armed_reg && settle_cnt_reg == 32'h0000_0000;
		end
	end
	// A shutdown request written early is held and served once settled.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_shutdown <= 1'b1;
		end else if (o_settled) begin
			o_shutdown <= sysctl2_reg[`CBSS_SHUTDOWN_BIT]; // R15
		end
	end

	// ------------------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------------------
	assign bus_start = (req.rd || req.wr) && bus_st_reg == cbss_pkg::CBSS_BUS_IDLE &&
		cp_st_reg == cbss_pkg::CBSS_CP_IDLE && !cp_start;
	always_comb begin
		rb_next = 32'h0000_0000;
		if (req_slot.hit) begin
			rb_next = upd_mode ? coef_word(mem_rdata) : coef_word(active_reg[req_slot.slot]);
		end else begin
			unique case (req.idx)
				`CBSS_IDX_BANKMODE: rb_next = {29'h0000_0000, mode_reg};
				`CBSS_IDX_SYSCTL2: rb_next = {24'h00_0000, sysctl2_reg};
				`CBSS_IDX_TRIM: rb_next = {24'h00_0000, trim_reg};
				`CBSS_IDX_RAMP: rb_next = {27'h000_0000, o_ramp_period};
				`CBSS_IDX_STATUS: rb_next = {25'h000_0000, o_settled, o_shutdown,
					cp_st_reg == cbss_pkg::CBSS_CP_RUN, o_active_bank, i_rate_code};
				default: rb_next = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_st_reg <= cbss_pkg::CBSS_BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			unique case (bus_st_reg)
				cbss_pkg::CBSS_BUS_IDLE: begin
					if (bus_start) begin
						bus_st_reg <= cbss_pkg::CBSS_BUS_PREP;
					end
				end
				cbss_pkg::CBSS_BUS_PREP: begin
					bus_st_reg <= cbss_pkg::CBSS_BUS_ANS;
					o_avs_waitrequest <= 1'b0;
					o_avs_readdata <= req.rd ? rb_next : 32'h0000_0000;
				end
				cbss_pkg::CBSS_BUS_ANS: begin
					bus_st_reg <= cbss_pkg::CBSS_BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_bus_answer_two: assert property (bus_start |=> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("answer not two cycles after start");
	a_disabled_write_now: assert property ( // R3
		take_wr && req_slot.hit && mode_reg == `CBSS_MODE_DIS
		|=> active_reg[$past(req_slot.slot)] == $past(req.wdata[25:0]))
		else $error("disabled-mode write did not take effect");
	a_update_keeps_active: assert property ( // R8
		take_wr && req_slot.hit && upd_mode |=> $stable(active_reg))
		else $error("bank update touched active coefficients");
	a_no_reload_manual: assert property ( // R4
		mode_reg != `CBSS_MODE_AUTO && cp_st_reg == cbss_pkg::CBSS_CP_IDLE
		|=> cp_st_reg == cbss_pkg::CBSS_CP_IDLE)
		else $error("reload started outside automatic mode");
	a_auto_reload_start: assert property ( // R6
		cp_start |=> cp_st_reg == cbss_pkg::CBSS_CP_RUN && o_active_bank == $past(
		bank_of_rate(i_rate_code)))
		else $error("automatic mode did not load mapped bank");
	a_copy_length: assert property ( // R1
		cp_start |=> (cp_st_reg == cbss_pkg::CBSS_CP_RUN) ##22
		(cp_st_reg == cbss_pkg::CBSS_CP_RUN) ##1 (cp_st_reg == cbss_pkg::CBSS_CP_IDLE))
		else $error("bank copy length wrong");
	a_settle_gate: assert property ( // R15
		!o_settled |=> $stable(o_shutdown))
		else $error("shutdown changed before settle time");
	a_upper_bits_zero: assert property ( // R11
		!o_avs_waitrequest && req_slot.hit |-> o_avs_readdata[31:26] == 6'h00)
		else $error("coefficient upper bits not zero");
	a_ramp_field: assert property ( // R22
		take_wr && req.idx == `CBSS_IDX_RAMP |=> o_ramp_period == $past(req.wdata[4:0]))
		else $error("ramp period field not written");
	c_bank_update: cover property (take_wr && mem_we);
	c_auto_reload: cover property (cp_start ##24 cp_st_reg == cbss_pkg::CBSS_CP_IDLE);
	c_shutdown_exit: cover property ($fell(o_shutdown));

endmodule : cbss_top
`default_nettype wire

// ### sim/cbss_host_model.sv
// Host controller model: Avalon-MM master that performs whole-word register accesses.
`default_nettype none
module cbss_host_model (
	input wire logic i_clock,
	input wire logic i_waitrequest,
	input wire logic [31:0] i_readdata,
	output logic [9:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_address = 10'h000;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
	end

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------
	// Each access carries one full 32-bit word; the spare edge at the end keeps
	// a following call from raising the strobe in the edge that dropped it.
	task automatic bus_write(input logic [7:0] idx, input logic [31:0] data);
		o_address <= {idx, 2'b00};
		o_writedata <= data;
		o_write <= 1'b1;
		@(posedge i_clock);
		while (i_waitrequest !== 1'b0) @(posedge i_clock);
		o_write <= 1'b0;
		@(posedge i_clock);
	endtask : bus_write

	task automatic bus_read(input logic [7:0] idx, output logic [31:0] data);
		o_address <= {idx, 2'b00};
		o_read <= 1'b1;
		@(posedge i_clock);
		while (i_waitrequest !== 1'b0) @(posedge i_clock);
		data = i_readdata;
		o_read <= 1'b0;
		@(posedge i_clock);
	endtask : bus_read

endmodule : cbss_host_model
`default_nettype wire

// ### sim/cbss_top_test.sv
// Self-checking testbench of the coefficient bank sequencer.
`default_nettype none
`include "cbss_consts.svh"
module cbss_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Short settle and ramp counts keep the run brief; field 2 gives 50 + 10 cycles.
	localparam int SETTLE = 50;
	localparam int STEP = 4;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [1:0] i_rate_code = 2'h0;
	logic [4:0] i_coef_rd_slot = 5'h00;
	logic [9:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	cbss_pkg::cbss_coef_t coef;
	logic shutdown;
	logic [4:0] ramp;
	logic [1:0] bank;
	logic settled;
	int n_errors = 0;
	int n_tests = 0;

	always #25 i_clock = ~i_clock;

	cbss_top #(.SETTLE_CYCLES(SETTLE), .RAMP_STEP_CYCLES(STEP)) i_cbss_top (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_rate_code(i_rate_code), .i_coef_rd_slot(i_coef_rd_slot), .o_coef_rd_data(coef),
		.o_shutdown(shutdown), .o_ramp_period(ramp), .o_active_bank(bank),
		.o_settled(settled)
	);

	cbss_host_model i_cbss_host_model (
		.i_clock(i_clock), .i_waitrequest(avs_waitrequest), .i_readdata(avs_readdata),
		.o_address(avs_address), .o_read(avs_read), .o_write(avs_write),
		.o_writedata(avs_writedata)
	);

	// ------------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		i_cbss_host_model.bus_read(idx, d);
		check("readdata", d, exp);
	endtask : rd_check

	// The first edge after the slot is set registers its coefficient; the check follows the second edge.
	task automatic coef_is(input logic [4:0] s, input logic [31:0] exp);
		i_coef_rd_slot <= s;
		repeat (2) @(posedge i_clock);
		check("coef", {6'h00, coef}, exp);
	endtask : coef_is

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		check("waitrequest", {31'h0, avs_waitrequest}, 32'h1);
		check("shutdown", {31'h0, shutdown}, 32'h1);
		check("settled", {31'h0, settled}, 32'h0);
		check("bank", {30'h0, bank}, 32'h0);
		rd_check(`CBSS_IDX_BANKMODE, 32'h0000_0000);
		rd_check(8'h70, 32'h0000_0000);
	endtask : t_reset

	task automatic t_disabled();
		i_cbss_host_model.bus_write(`CBSS_BK_A_LO, 32'hFFE3_9EA8);
		coef_is(5'd0, 32'h03E3_9EA8);
		check("sign", {31'h0, $signed(coef) < 0}, 32'h1);
		rd_check(`CBSS_BK_A_LO, 32'h03E3_9EA8);
		i_cbss_host_model.bus_write(`CBSS_BK_D, 32'h0080_0000);
		coef_is(5'd21, 32'h0080_0000);
		i_rate_code <= 2'h3;
		repeat (40) @(posedge i_clock);
		coef_is(5'd0, 32'h03E3_9EA8);
	endtask : t_disabled

	task automatic t_settle();
		i_cbss_host_model.bus_write(`CBSS_IDX_RAMP, 32'hFFFF_FFE2);
		check("ramp", {27'h0, ramp}, 32'h2);
		i_cbss_host_model.bus_write(`CBSS_IDX_TRIM, 32'h0000_0000);
		i_cbss_host_model.bus_write(`CBSS_IDX_SYSCTL2, 32'h0000_0000);
		repeat (30) @(posedge i_clock);
		check("early shutdown", {31'h0, shutdown}, 32'h1);
		check("early settled", {31'h0, settled}, 32'h0);
		for (int k = 0; k < 40 && settled !== 1'b1; k++) @(posedge i_clock);
		check("settled", {31'h0, settled}, 32'h1);
		repeat (4) @(posedge i_clock);
		check("exit shutdown", {31'h0, shutdown}, 32'h0);
		i_cbss_host_model.bus_write(`CBSS_IDX_SYSCTL2, 32'h0000_0040);
		repeat (4) @(posedge i_clock);
		check("enter shutdown", {31'h0, shutdown}, 32'h1);
		i_cbss_host_model.bus_write(`CBSS_IDX_SYSCTL2, 32'h0000_0000);
		repeat (4) @(posedge i_clock);
		check("leave shutdown", {31'h0, shutdown}, 32'h0);
	endtask : t_settle

	task automatic t_banks();
		int exp_bank [3] = '{1, 1, 2};
		for (int b = 1; b <= 3; b++) begin
			i_cbss_host_model.bus_write(`CBSS_IDX_BANKMODE, 32'(b));
			i_cbss_host_model.bus_write(`CBSS_BK_A_LO, 32'h0010_0000 * b);
			i_cbss_host_model.bus_write(`CBSS_BK_D, 32'h0000_0100 * b);
			rd_check(`CBSS_BK_A_LO, 32'h0010_0000 * b);
			coef_is(5'd0, 32'h03E3_9EA8);
		end
		i_rate_code <= 2'h0;
		// All three banks are loaded before automatic selection is enabled.
		i_cbss_host_model.bus_write(`CBSS_IDX_BANKMODE, 32'h0000_0004);
		repeat (40) @(posedge i_clock);
		check("bank", {30'h0, bank}, 32'h0);
		coef_is(5'd0, 32'h0010_0000);
		coef_is(5'd21, 32'h0000_0100);
		for (int r = 1; r <= 3; r++) begin
			i_rate_code <= 2'(r);
			repeat (40) @(posedge i_clock);
			check("bank", {30'h0, bank}, 32'(exp_bank[r - 1]));
			coef_is(5'd0, 32'h0010_0000 * (exp_bank[r - 1] + 1));
			coef_is(5'd21, 32'h0000_0100 * (exp_bank[r - 1] + 1));
		end
		// Settled, running, copy idle, third bank, rate code 3.
		rd_check(`CBSS_IDX_STATUS, 32'h0000_004B);
	endtask : t_banks

	// Shutdown comes first, then reset; the inputs are parked low only after reset has held.
	task automatic t_power_down();
		i_cbss_host_model.bus_write(`CBSS_IDX_SYSCTL2, 32'h0000_0040);
		repeat (4) @(posedge i_clock);
		check("off shutdown", {31'h0, shutdown}, 32'h1);
		i_rst_n <= 1'b0;
		repeat (40) @(posedge i_clock);
		i_rate_code <= 2'h0;
		i_coef_rd_slot <= 5'h00;
		@(posedge i_clock);
		check("reset bank", {30'h0, bank}, 32'h0);
		check("reset settled", {31'h0, settled}, 32'h0);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		rd_check(`CBSS_IDX_BANKMODE, 32'h0000_0000);
		rd_check(`CBSS_IDX_SYSCTL2, 32'h0000_0040);
		coef_is(5'd0, 32'h0000_0000);
	endtask : t_power_down

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		t_reset();
		t_disabled();
		t_settle();
		t_banks();
		t_power_down();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		test_done();
	end

endmodule : cbss_top_test
`default_nettype wire
